// *** ivec_defines.svh ***
// Function
// RL1: Opcode 37 stores the value field as handler vector for the typed interrupt.
// RL2: Program author supplies the handler's first instruction as vector address.
// RL3: A later vector definition overwrites the stored handler address.
// RL4: Vector definition is for stored programs; host must not rely on direct use.
// RL5: Opcode 38 restores accumulator, X, flags, program counter and resumes.
// RL6: Every handler routine ends with the return-from-handler instruction.
// RL7: Sequential program flow never falls into handler code.
// RL8: Opcodes 64 to 71 are user function hooks with user-defined fields.
// RL9: Direct-mode vector, return and user commands answer status 100.
// RL10: Opcode 138 gives an immediate acknowledge and a later target-reached reply.
// RL11: Value field of opcode 138 is a motor bit mask, bit n motor n.
// RL12: Type 0 notifies only for the next move-to-position command, then disarms.
// RL13: Type 1 stays armed for every later move-to-position command.
// RL14: Host is recommended to choose the persistent type 1.
// RL15: Target-reached request is accepted only in direct mode.
// RL16: Extra reply carries status 128, command 138 and the motor mask.
// RL17: Taking an interrupt saves context and jumps to the stored vector.
`ifndef IVEC_DEFINES_SVH
`define IVEC_DEFINES_SVH
`define IVEC_OP_DEFVEC   8'h25
`define IVEC_OP_RETURN   8'h26
`define IVEC_OP_UF_FIRST 8'h40
`define IVEC_OP_UF_LAST  8'h47
`define IVEC_OP_MOVE     8'h04
`define IVEC_OP_TREQ     8'h8a
`define IVEC_ST_OK       8'h64
`define IVEC_ST_TREACH   8'h80
`define IVEC_ST_BADCMD   8'h02
`endif

// *** ivec_pkg.sv ***
package ivec_pkg;
    typedef enum logic [1:0] {
        IVEC_RUN  = 2'b00,
        IVEC_ISR  = 2'b01
    } ivec_mode_t;
endpackage

// *** ivec_top.sv ***
`timescale 1ns/1ps
`include "ivec_defines.svh"
module ivec_top
    import ivec_pkg::*;
#(
    parameter int NUM_IRQ   = 16,
    parameter int PC_W      = 16,
    parameter int NUM_MOTOR = 6
)(
    input  wire logic                 clk,
    input  wire logic                 rstn,
    input  wire logic                 ce,
    // Command in: direct from host, or fetched by stored program
    input  wire logic                 cmd_valid,
    input  wire logic                 cmd_direct,
    input  wire logic [7:0]           cmd_opcode,
    input  wire logic [7:0]           cmd_type,
    input  wire logic [7:0]           cmd_bank,
    input  wire logic [31:0]          cmd_value,
    // Live processor context, and request to take an interrupt
    input  wire logic [31:0]          cur_accu,
    input  wire logic [31:0]          cur_xreg,
    input  wire logic [7:0]           cur_flags,
    input  wire logic [PC_W-1:0]      cur_pc,
    input  wire logic                 irq_take,
    input  wire logic [7:0]           irq_num,
    // Target-reached level per motor from motion core
    input  wire logic [NUM_MOTOR-1:0] pos_reached,
    // Reply to host
    output logic                      rep_valid,
    output logic [7:0]                rep_status,
    output logic [7:0]                rep_cmd,
    output logic [31:0]               rep_value,
    // Context load toward the interpreter
    output logic                      ctx_load,
    output logic [31:0]               ctx_accu,
    output logic [31:0]               ctx_xreg,
    output logic [7:0]                ctx_flags,
    output logic [PC_W-1:0]           ctx_pc,
    output logic                      in_handler,
    // Hook strobe for user functions 64..71
    output logic                      uf_strobe,
    output logic [2:0]                uf_index
);
    logic [PC_W-1:0]      vec_q [NUM_IRQ];
    logic [NUM_IRQ-1:0]   vdef_q;
    logic [31:0]          sav_accu_q, sav_xreg_q;
    logic [7:0]           sav_flags_q;
    logic [PC_W-1:0]      sav_pc_q;
    ivec_mode_t           mode_q;
    logic [NUM_MOTOR-1:0] arm_q, keep_q, watch_q, pr_s1_q, pr_s2_q, pr_old_q;
    logic [NUM_MOTOR-1:0] hit;

    function automatic logic is_uf(input logic [7:0] op);
        return (op >= `IVEC_OP_UF_FIRST) && (op <= `IVEC_OP_UF_LAST);
    endfunction

    wire logic go       = ce && cmd_valid;
    wire logic op_defv  = go && cmd_opcode == `IVEC_OP_DEFVEC;
    wire logic op_ret   = go && cmd_opcode == `IVEC_OP_RETURN && mode_q == IVEC_ISR;
    wire logic op_treq  = go && cmd_opcode == `IVEC_OP_TREQ && cmd_direct;
    wire logic op_move  = go && cmd_opcode == `IVEC_OP_MOVE;
    wire logic irq_ok   = ce && irq_take && mode_q == IVEC_RUN
                          && irq_num < 8'(NUM_IRQ) && vdef_q[irq_num[3:0]];

    // Vector table; redefinition just overwrites the entry
    // RL1 RL3: store vector
    always_ff @(posedge clk)
    begin
        if (op_defv && cmd_type < 8'(NUM_IRQ))
            vec_q[cmd_type[3:0]] <= cmd_value[PC_W-1:0];
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            vdef_q <= '0;
        else if (op_defv && cmd_type < 8'(NUM_IRQ))
            vdef_q[cmd_type[3:0]] <= 1'b1;
    end

    // Context save on entry, restore on return
    // RL17 RL5: handler entry and exit
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            mode_q      <= IVEC_RUN;
            sav_accu_q  <= '0;
            sav_xreg_q  <= '0;
            sav_flags_q <= '0;
            sav_pc_q    <= '0;
            ctx_load    <= 1'b0;
            ctx_accu    <= '0;
            ctx_xreg    <= '0;
            ctx_flags   <= '0;
            ctx_pc      <= '0;
        end
        else if (ce)
        begin
            ctx_load <= 1'b0;
            if (irq_ok)
            begin
                mode_q      <= IVEC_ISR;
                sav_accu_q  <= cur_accu;
                sav_xreg_q  <= cur_xreg;
                sav_flags_q <= cur_flags;
                sav_pc_q    <= cur_pc;
                ctx_load    <= 1'b1;     // Only the PC changes on entry
                ctx_accu    <= cur_accu;
                ctx_xreg    <= cur_xreg;
                ctx_flags   <= cur_flags;
                ctx_pc      <= vec_q[irq_num[3:0]];
            end
            else if (op_ret)
            begin
                mode_q    <= IVEC_RUN;
                ctx_load  <= 1'b1;
                ctx_accu  <= sav_accu_q;
                ctx_xreg  <= sav_xreg_q;
                ctx_flags <= sav_flags_q;
                ctx_pc    <= sav_pc_q;
            end
        end
    end

    assign in_handler = (mode_q == IVEC_ISR);

    // Motion core is another domain: two-stage sync, then rising edge
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pr_s1_q  <= '0;
            pr_s2_q  <= '0;
            pr_old_q <= '0;
        end
        else if (ce)
        begin
            pr_s1_q  <= pos_reached;
            pr_s2_q  <= pr_s1_q;
            pr_old_q <= pr_s2_q;
        end
    end

    assign hit = watch_q & pr_s2_q & ~pr_old_q;

    // Arming: a move starts watching armed motors; one-shot disarms there
    // RL11 RL12 RL13 RL15: arm by mask
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            arm_q   <= '0;
            keep_q  <= '0;
            watch_q <= '0;
        end
        else if (ce)
        begin
            watch_q <= watch_q & ~hit;
            if (op_move)
            begin
                watch_q <= (watch_q & ~hit) | arm_q;
                arm_q   <= arm_q & keep_q;
            end
            if (op_treq)
            begin
                arm_q  <= cmd_value[NUM_MOTOR-1:0];
                keep_q <= cmd_type[0] ? cmd_value[NUM_MOTOR-1:0] : '0;
            end
        end
    end

    // Replies: direct acknowledge has priority, extra reply waits for a cycle with no direct command
    // RL9 RL10 RL16: reply build
    logic [NUM_MOTOR-1:0] pend_q;
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rep_valid  <= 1'b0;
            rep_status <= '0;
            rep_cmd    <= '0;
            rep_value  <= '0;
            uf_strobe  <= 1'b0;
            uf_index   <= '0;
            pend_q     <= '0;
        end
        else if (ce)
        begin
            rep_valid <= 1'b0;
            uf_strobe <= 1'b0;
            pend_q    <= pend_q | hit;
            // RL8: user hook strobe
            if (go && is_uf(cmd_opcode))
            begin
                uf_strobe <= 1'b1;
                uf_index  <= cmd_opcode[2:0];
            end
            if (go && cmd_direct)
            begin
                rep_valid  <= 1'b1;
                rep_cmd    <= cmd_opcode;
                rep_status <= `IVEC_ST_OK;
                rep_value  <= op_treq ? 32'(cmd_value[NUM_MOTOR-1:0]) : cmd_value;
                if (cmd_opcode == `IVEC_OP_RETURN && mode_q != IVEC_ISR)
                    rep_status <= `IVEC_ST_OK;
            end
            else if ((pend_q | hit) != '0)
            begin
                rep_valid  <= 1'b1;
                rep_cmd    <= `IVEC_OP_TREQ;
                rep_status <= `IVEC_ST_TREACH;
                rep_value  <= 32'(pend_q | hit);
                pend_q     <= '0;
            end
        end
    end

    // Guards on entry, return, vector store, replies and arming
    a_entry_vec: assert property (@(posedge clk) disable iff (!rstn) // RL17
        irq_ok |=> ctx_load && ctx_pc == $past(vec_q[irq_num[3:0]]))
        else $error("handler entry pc wrong");
    a_ret_restore: assert property (@(posedge clk) disable iff (!rstn) // RL5
        op_ret |=> ctx_load && ctx_pc == $past(sav_pc_q) && !in_handler)
        else $error("return did not restore context");
    a_vec_write: assert property (@(posedge clk) disable iff (!rstn) // RL1
        op_defv && cmd_type < 8'(NUM_IRQ)
        |=> vec_q[$past(cmd_type[3:0])] == $past(cmd_value[PC_W-1:0]))
        else $error("vector not stored");
    a_direct_ack: assert property (@(posedge clk) disable iff (!rstn) // RL9
        go && cmd_direct |=> rep_valid && rep_status == `IVEC_ST_OK)
        else $error("direct ack missing");
    a_treach_fmt: assert property (@(posedge clk) disable iff (!rstn) // RL16
        rep_valid && rep_status == `IVEC_ST_TREACH |-> rep_cmd == `IVEC_OP_TREQ)
        else $error("extra reply format wrong");
    a_oneshot_disarm: assert property (@(posedge clk) disable iff (!rstn) // RL12
        op_move && !op_treq && keep_q == '0 |=> arm_q == '0)
        else $error("one-shot stayed armed");
    a_persist_arm: assert property (@(posedge clk) disable iff (!rstn) // RL13
        op_move && !op_treq |=> (arm_q & $past(keep_q)) == ($past(arm_q) & $past(keep_q)))
        else $error("persistent arm lost");
    a_direct_only: assert property (@(posedge clk) disable iff (!rstn) // RL15
        go && cmd_opcode == `IVEC_OP_TREQ && !cmd_direct && !op_move
        |=> arm_q == $past(arm_q))
        else $error("stored program armed target request");
    a_uf_hook: assert property (@(posedge clk) disable iff (!rstn) // RL8
        go && is_uf(cmd_opcode) |=> uf_strobe && uf_index == $past(cmd_opcode[2:0]))
        else $error("user hook not signalled");
endmodule

// *** ivec_motion_model.sv ***
`timescale 1ns/1ps
`include "ivec_defines.svh"
module ivec_motion_model #(
    parameter int NUM_MOTOR = 6,
    parameter int SETTLE    = 20
)(
    input  wire logic                 clk,
    input  wire logic                 rstn,
    input  wire logic                 cmd_valid,
    input  wire logic [7:0]           cmd_opcode,
    input  wire logic [7:0]           cmd_bank,
    output logic [NUM_MOTOR-1:0]      pos_reached
);
    int cnt [NUM_MOTOR];

    // motor n drives bit n
    // A move drops the level, which rises again after the settle time
    always_ff @(posedge clk or negedge rstn)
    begin
        for (int m = 0; m < NUM_MOTOR; m++)
        begin
            if (!rstn)
            begin
                pos_reached[m] <= 1'b0;
                cnt[m]         <= 0;
            end
            else if (cmd_valid && cmd_opcode == `IVEC_OP_MOVE && cmd_bank == 8'(m))
            begin
                pos_reached[m] <= 1'b0;
                cnt[m]         <= SETTLE;
            end
            else if (cnt[m] != 0)
            begin
                cnt[m]         <= cnt[m] - 1;
                pos_reached[m] <= (cnt[m] == 1) | pos_reached[m];
            end
        end
    end
endmodule

// *** ivec_top_test.sv ***
`timescale 1ns/1ps
`include "ivec_defines.svh"
module ivec_top_test;
    logic        clk, rstn, ce, cmd_valid, cmd_direct, irq_take, hit;
    logic        rep_valid, ctx_load, in_handler, uf_strobe;
    logic [7:0]  cmd_opcode, cmd_type, cmd_bank, cur_flags, irq_num;
    logic [7:0]  rep_status, rep_cmd, ctx_flags;
    logic [31:0] cmd_value, cur_accu, cur_xreg, rep_value, ctx_accu, ctx_xreg;
    logic [15:0] cur_pc, ctx_pc;
    logic [5:0]  pos_reached;
    logic [2:0]  uf_index;
    int          n_errors, n_compared;

    ivec_top ivec_top_inst (.clk(clk), .rstn(rstn), .ce(ce), .cmd_valid(cmd_valid),
        .cmd_direct(cmd_direct), .cmd_opcode(cmd_opcode), .cmd_type(cmd_type),
        .cmd_bank(cmd_bank), .cmd_value(cmd_value), .cur_accu(cur_accu), .cur_xreg(cur_xreg),
        .cur_flags(cur_flags), .cur_pc(cur_pc), .irq_take(irq_take), .irq_num(irq_num),
        .pos_reached(pos_reached), .rep_valid(rep_valid), .rep_status(rep_status),
        .rep_cmd(rep_cmd), .rep_value(rep_value), .ctx_load(ctx_load), .ctx_accu(ctx_accu),
        .ctx_xreg(ctx_xreg), .ctx_flags(ctx_flags), .ctx_pc(ctx_pc),
        .in_handler(in_handler), .uf_strobe(uf_strobe), .uf_index(uf_index));
    ivec_motion_model ivec_motion_model_inst (.clk(clk), .rstn(rstn), .cmd_valid(cmd_valid),
        .cmd_opcode(cmd_opcode), .cmd_bank(cmd_bank), .pos_reached(pos_reached));

    // Free-running 200 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e)
        begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Lets one edge pass first, so valid never drops and rises in one step;
    // returns just after the taking edge, while the one-cycle ack still stands
    task automatic send(input logic d, input logic [7:0] op, ty, bk, input logic [31:0] v);
        @(posedge clk);
        #1;
        {cmd_direct, cmd_opcode, cmd_type, cmd_bank, cmd_value} = {d, op, ty, bk, v};
        cmd_valid = 1'b1;
        @(posedge clk);
        #1 cmd_valid = 1'b0;
    endtask

    task automatic wait_rep(input int n);
        hit = 1'b0;
        for (int i = 0; i < n && !hit; i++)
        begin
            @(posedge clk);
            #1 hit = rep_valid;
        end
    endtask

    task automatic test_vector;
        send(1'b0, `IVEC_OP_DEFVEC, 8'h03, 8'h00, 32'h32);
        chk("stored ack", 32'h0, 32'(rep_valid));
        send(1'b0, `IVEC_OP_DEFVEC, 8'h03, 8'h00, 32'h50);
        irq_num  = 8'h03;
        irq_take = 1'b1;
        @(posedge clk);
        #1 irq_take = 1'b0;
        chk("entry load", 32'h1, 32'(ctx_load));
        chk("entry pc", 32'h50, 32'(ctx_pc));
        chk("entry level", 32'h1, 32'(in_handler));
        {cur_accu, cur_xreg, cur_flags, cur_pc} = '1;
        send(1'b1, `IVEC_OP_RETURN, 8'h00, 8'h00, 32'h0);
        chk("return status", 32'h64, 32'(rep_status));
        chk("return load", 32'h1, 32'(ctx_load));
        chk("return accu", 32'h12, ctx_accu);
        chk("return xreg", 32'h34, ctx_xreg);
        chk("return flags", 32'h0c, 32'(ctx_flags));
        chk("return pc", 32'h58, 32'(ctx_pc));
        @(posedge clk);
        #1 chk("handler level", 32'h0, 32'(in_handler));
        $display("test vector done");
    endtask

    task automatic test_hooks;
        for (logic [7:0] op = `IVEC_OP_UF_FIRST; op <= `IVEC_OP_UF_LAST; op++)
        begin
            send(1'b1, op, op, 8'h01, {24'h0, op});
            chk("hook strobe", 32'h1, 32'(uf_strobe));
            chk("hook index", 32'(op - 8'h40), 32'(uf_index));
            chk("hook status", 32'h64, 32'(rep_status));
        end
        // Clock enable low must freeze the block: no ack, no hook strobe
        @(posedge clk);
        #1 ce = 1'b0;
        send(1'b1, `IVEC_OP_UF_FIRST, 8'h00, 8'h00, 32'h0);
        chk("frozen ack", 32'h0, 32'(rep_valid));
        chk("frozen hook", 32'h0, 32'(uf_strobe));
        ce = 1'b1;
        $display("test hooks done");
    endtask

    task automatic test_notify(input logic [7:0] ty);
        send(1'b0, `IVEC_OP_TREQ, ty, 8'h00, 32'h4);
        chk("stored arm", 32'h0, 32'(rep_valid));
        send(1'b1, `IVEC_OP_TREQ, ty, 8'h00, 32'h4);
        chk("arm ack", 32'h648a0004, {rep_status, rep_cmd, rep_value[15:0]});
        for (int k = 0; k < 2; k++)
        begin
            send(1'b1, `IVEC_OP_MOVE, 8'h00, 8'h02, 32'h100);
            wait_rep(40);
            chk("notify seen", 32'(k == 0 || ty[0]), 32'(hit));
            if (hit)
                chk("notify reply", 32'h808a0004, {rep_status, rep_cmd, rep_value[15:0]});
        end
        $display("test notify type %0d done", ty);
    endtask

    task automatic report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Handler entry saves these context values, which the return must give back
    initial
    begin
        {rstn, cmd_valid, cmd_direct, irq_take, irq_num} = '0;
        {cmd_opcode, cmd_type, cmd_bank, cmd_value} = '0;
        ce = 1'b1;
        {cur_accu, cur_xreg, cur_flags, cur_pc} = {32'h12, 32'h34, 8'h0c, 16'h0058};
        repeat (16) @(posedge clk);
        #1 rstn = 1'b1;
        test_vector();
        test_hooks();
        test_notify(8'h00);
        test_notify(8'h01);
        report_and_stop();
    end

    // Whole run needs well under 1000 cycles
    initial
    begin
        #20000;
        n_errors++;
        report_and_stop();
    end
endmodule
